// ==== rtl/ramp_and_param_control.v ====
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "ramp_param_map.vh"

// Overview of operation
// - accel time spans zero to base frequency
// - decel time spans base frequency to zero
// - four time pairs picked by terminals
// - restore codes 1/2 act, then clear
// - code 1 reloads defaults, keeps motor/faults
// - code 2 clears faults and totals
// - lock set blocks all writes but lock
// - retention only for digital frequency source
// - retain 0 reloads keypad setpoint at stop
// - retain 1 keeps last setpoint at stop
// - time unit scales counts 1s/0.1s/0.01s
// - base: max, set frequency, or 100 Hz
// - auto fan follows run, 30 s off-delay
// - auto fan also on above 50 degrees
// - fan option 1 runs fan always
// - one or two decimals, rescales frequencies
// - factory restore leaves decimals alone
module ramp_and_param_control #(
   parameter TICK_CYCLES = `TICK_CYCLES,
   parameter FAN_DELAY_TICKS = `FAN_DELAY_TICKS
) (
   // clock, reset, enable
   input wire clk,
   input wire rst,
   input wire ce,
   // register port
   input wire [4:0] addr,
   input wire [15:0] wrData,
   input wire wrStrobe,
   input wire rdStrobe,
   output reg [15:0] rdData_r,
   // drive status from core logic
   input wire runCmd,
   input wire freqSrcDigital,
   input wire [7:0] moduleTemp,
   input wire faultEvent,
   input wire [15:0] faultCode,
   input wire energyPulse,
   // terminal pins
   input wire [1:0] rampGroupPins,
   // outputs
   output wire [15:0] outFreq_r,
   output reg fanOn_r
);

// ----------------------------------------
// helpers
// ----------------------------------------
function [15:0] hzScaled;
   input [15:0] hz;
   input [1:0] dec;
   begin
      hzScaled = (dec == `DEC_ONE) ? hz * 16'h000A : hz * 16'h0064;
   end
endfunction

function [15:0] rescale;
   input [15:0] val;
   input up;
   begin
      rescale = up ? val * 16'h000A : val / 16'h000A;
   end
endfunction

// ----------------------------------------
// parameter store
// ----------------------------------------
reg [15:0] accelTime_r [0:3];
reg [15:0] decelTime_r [0:3];
reg [1:0] restoreCmd_r;
reg writeLock_r;
reg retain_r;
reg [1:0] timeUnit_r;
reg [1:0] baseSel_r;
reg fanOption_r;
reg [1:0] decimals_r;
reg [15:0] keypadSp_r;
reg [15:0] maxFreq_r;
reg [15:0] digitalSp_r;
reg [15:0] motorFreq_r;
reg [15:0] runTime_r;
reg [15:0] pwrTime_r;
reg [15:0] energy_r;
reg [15:0] faultRec_r;
integer i;

// ----------------------------------------
// terminal synchroniser
// ----------------------------------------
reg [1:0] grpS1_r;
reg [1:0] grpS2_r;
reg [1:0] grpS3_r;
reg [1:0] rampGroup_r;

always @(posedge clk)
begin
   if (rst)
   begin
      grpS1_r <= 2'h0;
      grpS2_r <= 2'h0;
      grpS3_r <= 2'h0;
      rampGroup_r <= 2'h0;
   end
   else if (ce)
   begin
      grpS1_r <= rampGroupPins;
      grpS2_r <= grpS1_r;
      grpS3_r <= grpS2_r;
      if (grpS2_r == grpS3_r)
         rampGroup_r <= grpS3_r;
   end
end

// ----------------------------------------
// 10 ms tick and seconds
// ----------------------------------------
reg [23:0] tickCnt_r;
reg [6:0] secCnt_r;
reg tick_r;
wire secPulse = tick_r && (secCnt_r == `TICKS_PER_S - 1);

always @(posedge clk)
begin
   if (rst)
   begin
      tickCnt_r <= 24'h000000;
      secCnt_r <= 7'h00;
      tick_r <= 1'b0;
   end
   else if (ce)
   begin
      tick_r <= (tickCnt_r == TICK_CYCLES - 1);
      if (tickCnt_r == TICK_CYCLES - 1)
         tickCnt_r <= 24'h000000;
      else
         tickCnt_r <= tickCnt_r + 24'h000001;
      if (secPulse)
         secCnt_r <= 7'h00;
      else if (tick_r)
         secCnt_r <= secCnt_r + 7'h01;
   end
end

// ----------------------------------------
// register writes and restore
// ----------------------------------------
reg runPrev_r;
wire wrOk = wrStrobe && (!writeLock_r || addr == `REG_LOCK);
wire decWrite = wrOk && addr == `REG_DECIMALS &&
   (wrData[1:0] == `DEC_ONE || wrData[1:0] == `DEC_TWO) && wrData[1:0] != decimals_r;
wire scaleUp = decWrite && wrData[1:0] == `DEC_TWO;
wire scaleDown = decWrite && wrData[1:0] == `DEC_ONE;
wire stopEdge = runPrev_r && !runCmd;

always @(posedge clk)
begin
   if (rst)
   begin
      for (i = 0; i < 4; i = i + 1)
      begin
         accelTime_r[i] <= `DEF_RAMP_TIME;
         decelTime_r[i] <= `DEF_RAMP_TIME;
      end
      restoreCmd_r <= `RESTORE_NONE;
      writeLock_r <= 1'b0;
      retain_r <= `DEF_RETAIN;
      timeUnit_r <= `DEF_UNIT;
      baseSel_r <= `DEF_BASE_SEL;
      fanOption_r <= `DEF_FAN_OPT;
      decimals_r <= `DEF_DECIMALS;
      keypadSp_r <= hzScaled(`DEF_FREQ_HZ, `DEF_DECIMALS);
      maxFreq_r <= hzScaled(`DEF_FREQ_HZ, `DEF_DECIMALS);
      digitalSp_r <= hzScaled(`DEF_FREQ_HZ, `DEF_DECIMALS);
      motorFreq_r <= `DEF_MOTOR_FREQ;
      runTime_r <= 16'h0000;
      pwrTime_r <= 16'h0000;
      energy_r <= 16'h0000;
      faultRec_r <= 16'h0000;
      runPrev_r <= 1'b0;
   end
   else if (ce)
   begin
      runPrev_r <= runCmd;
      if (secPulse)
         pwrTime_r <= pwrTime_r + 16'h0001;
      if (secPulse && runCmd)
         runTime_r <= runTime_r + 16'h0001;
      if (energyPulse)
         energy_r <= energy_r + 16'h0001;
      if (faultEvent)
         faultRec_r <= faultCode;
      if (stopEdge && freqSrcDigital && !retain_r)
         digitalSp_r <= keypadSp_r;
      // act on pending code, then clear
      if (restoreCmd_r == `RESTORE_FACTORY)
      begin
         for (i = 0; i < 4; i = i + 1)
         begin
            accelTime_r[i] <= `DEF_RAMP_TIME;
            decelTime_r[i] <= `DEF_RAMP_TIME;
         end
         writeLock_r <= 1'b0;
         retain_r <= `DEF_RETAIN;
         timeUnit_r <= `DEF_UNIT;
         baseSel_r <= `DEF_BASE_SEL;
         fanOption_r <= `DEF_FAN_OPT;
         keypadSp_r <= hzScaled(`DEF_FREQ_HZ, decimals_r);
         maxFreq_r <= hzScaled(`DEF_FREQ_HZ, decimals_r);
         digitalSp_r <= hzScaled(`DEF_FREQ_HZ, decimals_r);
      end
      else if (restoreCmd_r == `RESTORE_RECORDS)
      begin
         faultRec_r <= 16'h0000;
         runTime_r <= 16'h0000;
         pwrTime_r <= 16'h0000;
         energy_r <= 16'h0000;
      end
      restoreCmd_r <= `RESTORE_NONE;
      if (wrOk && restoreCmd_r == `RESTORE_NONE)
      begin
         if (addr < `REG_RESTORE)
         begin
            if (wrData <= `MAX_TIME_COUNT)
            begin
               if (addr[2])
                  decelTime_r[addr[1:0]] <= wrData;
               else
                  accelTime_r[addr[1:0]] <= wrData;
            end
         end
         else
         begin
            case (addr)
               `REG_RESTORE:
               begin
                  if (wrData[1:0] == `RESTORE_FACTORY || wrData[1:0] == `RESTORE_RECORDS)
                     restoreCmd_r <= wrData[1:0];
               end
               `REG_LOCK: writeLock_r <= wrData[0];
               `REG_RETAIN: retain_r <= wrData[0];
               `REG_UNIT:
               begin
                  if (wrData[1:0] != 2'h3)
                     timeUnit_r <= wrData[1:0];
               end
               `REG_BASE_SEL:
               begin
                  if (wrData[1:0] != 2'h3)
                     baseSel_r <= wrData[1:0];
               end
               `REG_FAN_OPT: fanOption_r <= wrData[0];
               `REG_DECIMALS:
               begin
                  if (decWrite)
                  begin
                     decimals_r <= wrData[1:0];
                     keypadSp_r <= rescale(keypadSp_r, scaleUp);
                     maxFreq_r <= rescale(maxFreq_r, scaleUp);
                     digitalSp_r <= rescale(digitalSp_r, scaleUp);
                     motorFreq_r <= rescale(motorFreq_r, scaleUp);
                  end
               end
               `REG_KEYPAD_SP: keypadSp_r <= wrData;
               `REG_MAX_FREQ: maxFreq_r <= wrData;
               `REG_DIGITAL_SP: digitalSp_r <= wrData;
               `REG_MOTOR_FREQ: motorFreq_r <= wrData;
               default: ;
            endcase
         end
      end
   end
end

// ----------------------------------------
// ramp generator
// ----------------------------------------
wire [15:0] clampedSp = (digitalSp_r > maxFreq_r) ? maxFreq_r : digitalSp_r;
wire [15:0] target = runCmd ? clampedSp : 16'h0000;
reg [15:0] span;
reg [23:0] unitTicks;
wire [23:0] accelTicks = {8'h00, accelTime_r[rampGroup_r]} * unitTicks;
wire [23:0] decelTicks = {8'h00, decelTime_r[rampGroup_r]} * unitTicks;

always @*
begin
   // span the ramp times refer to
   case (baseSel_r)
      `BASE_MAX: span = maxFreq_r;
      `BASE_SET: span = clampedSp;
      `BASE_100HZ: span = hzScaled(`FIXED_BASE_HZ, decimals_r);
      default: span = maxFreq_r;
   endcase
   // 10 ms ticks per stored count
   case (timeUnit_r)
      `UNIT_1S: unitTicks = 24'h000064;
      `UNIT_100MS: unitTicks = 24'h00000A;
      `UNIT_10MS: unitTicks = 24'h000001;
      default: unitTicks = 24'h00000A;
   endcase
end

ramp_stepper stepper (
   .clk(clk),
   .rst(rst),
   .ce(ce),
   .tick(tick_r),
   .target(target),
   .span(span),
   .accelTicks(accelTicks),
   .decelTicks(decelTicks),
   .scaleUp(scaleUp),
   .scaleDown(scaleDown),
   .freq_r(outFreq_r)
);

// ----------------------------------------
// cooling fan
// ----------------------------------------
reg [15:0] fanDelay_r;

always @(posedge clk)
begin
   if (rst)
   begin
      fanOn_r <= 1'b0;
      fanDelay_r <= 16'h0000;
   end
   else if (ce)
   begin
      if (runCmd)
         fanDelay_r <= FAN_DELAY_TICKS[15:0];
      else if (tick_r && fanDelay_r != 16'h0000)
         fanDelay_r <= fanDelay_r - 16'h0001;
      fanOn_r <= fanOption_r || runCmd || fanDelay_r != 16'h0000 ||
         moduleTemp > `TEMP_LIMIT_C;
   end
end

// ----------------------------------------
// read port
// ----------------------------------------
always @(posedge clk)
begin
   if (rst)
      rdData_r <= 16'h0000;
   else if (ce)
   begin
      if (!rdStrobe)
         rdData_r <= 16'h0000;
      else if (addr < `REG_RESTORE)
         rdData_r <= addr[2] ? decelTime_r[addr[1:0]] : accelTime_r[addr[1:0]];
      else
      begin
         case (addr)
            `REG_RESTORE: rdData_r <= {14'h0000, restoreCmd_r};
            `REG_LOCK: rdData_r <= {15'h0000, writeLock_r};
            `REG_RETAIN: rdData_r <= {15'h0000, retain_r};
            `REG_UNIT: rdData_r <= {14'h0000, timeUnit_r};
            `REG_BASE_SEL: rdData_r <= {14'h0000, baseSel_r};
            `REG_FAN_OPT: rdData_r <= {15'h0000, fanOption_r};
            `REG_DECIMALS: rdData_r <= {14'h0000, decimals_r};
            `REG_KEYPAD_SP: rdData_r <= keypadSp_r;
            `REG_MAX_FREQ: rdData_r <= maxFreq_r;
            `REG_DIGITAL_SP: rdData_r <= digitalSp_r;
            `REG_MOTOR_FREQ: rdData_r <= motorFreq_r;
            `REG_OUT_FREQ: rdData_r <= outFreq_r;
            `REG_RUN_TIME: rdData_r <= runTime_r;
            `REG_PWR_TIME: rdData_r <= pwrTime_r;
            `REG_ENERGY: rdData_r <= energy_r;
            `REG_FAULT: rdData_r <= faultRec_r;
            `REG_STATUS: rdData_r <= {12'h000, rampGroup_r, runCmd, fanOn_r};
            default: rdData_r <= 16'h0000;
         endcase
      end
   end
end

endmodule

// ==== rtl/ramp_param_map.vh ====
`ifndef RAMP_PARAM_MAP_VH
`define RAMP_PARAM_MAP_VH

// ----------------------------------------
// register offsets (word index on addr)
// ----------------------------------------
`define REG_ACCEL_BASE 5'h00
`define REG_DECEL_BASE 5'h04
`define REG_RESTORE 5'h08
`define REG_LOCK 5'h09
`define REG_RETAIN 5'h0A
`define REG_UNIT 5'h0B
`define REG_BASE_SEL 5'h0C
`define REG_FAN_OPT 5'h0D
`define REG_DECIMALS 5'h0E
`define REG_KEYPAD_SP 5'h0F
`define REG_MAX_FREQ 5'h10
`define REG_DIGITAL_SP 5'h11
`define REG_MOTOR_FREQ 5'h12
`define REG_OUT_FREQ 5'h13
`define REG_RUN_TIME 5'h14
`define REG_PWR_TIME 5'h15
`define REG_ENERGY 5'h16
`define REG_FAULT 5'h17
`define REG_STATUS 5'h18

// ----------------------------------------
// codes and field values
// ----------------------------------------
`define RESTORE_NONE 2'h0
`define RESTORE_FACTORY 2'h1
`define RESTORE_RECORDS 2'h2
`define UNIT_1S 2'h0
`define UNIT_100MS 2'h1
`define UNIT_10MS 2'h2
`define BASE_MAX 2'h0
`define BASE_SET 2'h1
`define BASE_100HZ 2'h2
`define DEC_ONE 2'h1
`define DEC_TWO 2'h2
`define STAT_FAN_BIT 0
`define STAT_RUN_BIT 1
`define STAT_GROUP_LSB 2

// ----------------------------------------
// reset and factory values
// ----------------------------------------
`define DEF_RAMP_TIME 16'h0064
`define DEF_RETAIN 1'b1
`define DEF_UNIT 2'h1
`define DEF_BASE_SEL 2'h0
`define DEF_FAN_OPT 1'b0
`define DEF_DECIMALS 2'h2
`define DEF_FREQ_HZ 16'h0032
`define DEF_MOTOR_FREQ 16'h1388
`define FIXED_BASE_HZ 16'h0064
`define MAX_TIME_COUNT 16'hFDE8
`define TEMP_LIMIT_C 8'h32

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ 20000000
`define TICK_MS 10
`define TICK_CYCLES (`CLK_HZ / 1000 * `TICK_MS)
`define TICKS_PER_S (1000 / `TICK_MS)
`define FAN_DELAY_S 30
`define FAN_DELAY_TICKS (`FAN_DELAY_S * `TICKS_PER_S)

`endif

// ==== rtl/ramp_stepper.v ====
`timescale 1ns/10ps
`include "ramp_param_map.vh"

module ramp_stepper (
   // clock and control
   input wire clk,
   input wire rst,
   input wire ce,
   input wire tick,
   // ramp inputs
   input wire [15:0] target,
   input wire [15:0] span,
   input wire [23:0] accelTicks,
   input wire [23:0] decelTicks,
   // rescale request
   input wire scaleUp,
   input wire scaleDown,
   // result
   output reg [15:0] freq_r
);

reg [23:0] acc_r;
wire rising = target > freq_r;
wire [23:0] period = rising ? accelTicks : decelTicks;

always @(posedge clk)
begin
   if (rst)
   begin
      freq_r <= 16'h0000;
      acc_r <= 24'h000000;
   end
   else if (ce)
   begin
      if (scaleUp)
      begin
         freq_r <= freq_r * 16'h000A;
         acc_r <= 24'h000000;
      end
      else if (scaleDown)
      begin
         freq_r <= freq_r / 16'h000A;
         acc_r <= 24'h000000;
      end
      else if (freq_r == target)
         acc_r <= 24'h000000;
      else if (period == 24'h000000)
         freq_r <= target;
      // span per period, one count per cycle
      else if (acc_r >= period)
      begin
         acc_r <= acc_r - period;
         freq_r <= rising ? freq_r + 16'h0001 : freq_r - 16'h0001;
      end
      else if (tick)
         acc_r <= acc_r + {8'h00, span};
   end
end

endmodule

// ==== testbench/drive_side_model.sv ====
`timescale 1ns/10ps
module drive_side_model (
   // clock
   input wire clk,
   // requests from the bench
   input wire runReq,
   input wire srcReq,
   input wire [7:0] tempReq,
   input wire [1:0] grpReq,
   input wire faultReq,
   input wire [15:0] codeReq,
   input wire energyReq,
   // lines into the block
   output reg runCmd = 1'b0,
   output reg freqSrcDigital = 1'b1,
   output reg [7:0] moduleTemp = 8'h14,
   output reg [1:0] rampGroupPins = 2'h0,
   output reg faultEvent = 1'b0,
   output reg [15:0] faultCode = 16'h5A5A,
   output reg energyPulse = 1'b0
);
   always @(posedge clk)
   begin
      runCmd <= runReq;
      freqSrcDigital <= srcReq;
      moduleTemp <= tempReq;
      rampGroupPins <= grpReq;
      faultEvent <= faultReq;
      energyPulse <= energyReq;
      // code is only valid beside the event, so it churns otherwise
      faultCode <= faultReq ? codeReq : ~faultCode;
   end
endmodule

// ==== testbench/ramp_and_param_control_props.sv ====
`timescale 1ns/10ps
module ramp_and_param_control_props (
   // clock and reset
   input wire clk,
   input wire rst,
   // register port
   input wire [4:0] addr,
   input wire wrStrobe,
   input wire rdStrobe,
   input wire [15:0] rdData_r,
   // drive side
   input wire runCmd,
   input wire [7:0] moduleTemp,
   input wire [1:0] rampGroupPins,
   input wire [15:0] outFreq_r,
   input wire fanOn_r
);
   reg [1:0] quiet_r;
   reg [2:0] pinAge_r;
   reg [1:0] lastPins_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // writes may retarget or rescale the output, so steps count only in quiet spells
   always @(posedge clk)
   begin
      lastPins_r <= rampGroupPins;
      if (rst)
      begin
         quiet_r <= 2'h0;
         pinAge_r <= 3'h0;
      end
      else
      begin
         if (wrStrobe)
            quiet_r <= 2'h0;
         else if (quiet_r != 2'h3)
            quiet_r <= quiet_r + 2'h1;
         if (rampGroupPins != lastPins_r)
            pinAge_r <= 3'h0;
         else if (pinAge_r != 3'h7)
            pinAge_r <= pinAge_r + 3'h1;
      end
   end

   a_step_single: assert property (
      quiet_r == 2'h3 |-> outFreq_r - $past(outFreq_r) + 16'h0001 <= 16'h0002)
      else $error("output moved more than one count");
   a_stop_no_rise: assert property (
      !runCmd && !$past(runCmd) && quiet_r == 2'h3 |-> outFreq_r <= $past(outFreq_r))
      else $error("output rose while stopped");
   a_fan_run: assert property (runCmd |=> fanOn_r)
      else $error("fan off while running");
   a_fan_hold: assert property ($fell(runCmd) |-> fanOn_r [*8])
      else $error("fan dropped at stop");
   a_fan_temp: assert property (moduleTemp > 8'h32 |=> fanOn_r)
      else $error("fan off while hot");
   a_group_status: assert property (
      rdStrobe && addr == 5'h18 && pinAge_r > 3'h5 |=> rdData_r[3:2] == $past(rampGroupPins))
      else $error("active group differs from pins");
   a_read_pulse: assert property (!rdStrobe |=> rdData_r == 16'h0000)
      else $error("read data outside read cycle");
   a_unmapped_zero: assert property (rdStrobe && addr > 5'h18 |=> rdData_r == 16'h0000)
      else $error("unmapped read not zero");
endmodule

bind ramp_and_param_control ramp_and_param_control_props ramp_and_param_control_props_inst (
   .clk, .rst, .addr, .wrStrobe, .rdStrobe, .rdData_r, .runCmd, .moduleTemp,
   .rampGroupPins, .outFreq_r, .fanOn_r
);

// ==== testbench/ramp_and_param_control_tb_top.sv ====
`timescale 1ns/10ps
`include "ramp_param_map.vh"
module ramp_and_param_control_tb_top;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [4:0] addr = 5'h00;
   reg [15:0] wrData = 16'h0000;
   reg wrStrobe = 1'b0;
   reg rdStrobe = 1'b0;
   reg runReq = 1'b0;
   reg srcReq = 1'b1;
   reg [7:0] tempReq = 8'h14;
   reg [1:0] grpReq = 2'h0;
   reg faultReq = 1'b0;
   reg energyReq = 1'b0;
   wire [15:0] rdData_r;
   wire [15:0] outFreq_r;
   wire [15:0] faultCode;
   wire [7:0] moduleTemp;
   wire [1:0] rampGroupPins;
   wire fanOn_r;
   wire runCmd;
   wire freqSrcDigital;
   wire faultEvent;
   wire energyPulse;
   integer mismatches = 0;
   integer check_count = 0;

   always #25 clk = ~clk;

   drive_side_model drive_side_model_inst (.clk(clk), .runReq(runReq), .srcReq(srcReq),
      .tempReq(tempReq), .grpReq(grpReq), .faultReq(faultReq), .codeReq(16'hABCD),
      .energyReq(energyReq), .runCmd(runCmd), .freqSrcDigital(freqSrcDigital),
      .moduleTemp(moduleTemp), .rampGroupPins(rampGroupPins), .faultEvent(faultEvent),
      .faultCode(faultCode), .energyPulse(energyPulse));

   // tick must outlast the longest per-tick drain (100 steps) or ticks are dropped
   ramp_and_param_control #(.TICK_CYCLES(125), .FAN_DELAY_TICKS(5)) ramp_and_param_control_inst (
      .clk(clk), .rst(rst), .ce(1'b1), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
      .rdStrobe(rdStrobe), .rdData_r(rdData_r), .runCmd(runCmd),
      .freqSrcDigital(freqSrcDigital), .moduleTemp(moduleTemp), .faultEvent(faultEvent),
      .faultCode(faultCode), .energyPulse(energyPulse), .rampGroupPins(rampGroupPins),
      .outFreq_r(outFreq_r), .fanOn_r(fanOn_r));

   task final_report;
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task check(input [15:0] seen, input [15:0] exp);
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input [4:0] a, input [15:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
   endtask

   task rd(input [4:0] a, output [15:0] d);
      @(posedge clk);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      #1 d = rdData_r;
   endtask

   task rc(input [4:0] a, input [15:0] e);
      reg [15:0] d;
      rd(a, d);
      check(d, e);
   endtask

   task cyc(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task wait_freq(input [15:0] v, input integer lim, output integer n);
      n = 0;
      while (outFreq_r !== v && n < lim)
      begin
         @(posedge clk);
         #1 n = n + 1;
      end
   endtask

   task t_defaults;
      integer i;
      for (i = 0; i < 8; i = i + 1)
         rc(i[4:0], `DEF_RAMP_TIME);
      rc(`REG_UNIT, 16'h0001);
      rc(`REG_DECIMALS, 16'h0002);
      rc(`REG_RETAIN, 16'h0001);
      rc(5'h1F, 16'h0000);
      check(fanOn_r, 16'h0000);
   endtask

   task t_fan;
      wr(`REG_FAN_OPT, 16'h0000);
      @(posedge clk) runReq <= 1'b1;
      cyc(4);
      check(fanOn_r, 16'h0001);
      @(posedge clk) runReq <= 1'b0;
      cyc(300);
      check(fanOn_r, 16'h0001);
      cyc(500);
      check(fanOn_r, 16'h0000);
      @(posedge clk) tempReq <= 8'h33;
      cyc(4);
      check(fanOn_r, 16'h0001);
      @(posedge clk) tempReq <= 8'h32;
      cyc(4);
      check(fanOn_r, 16'h0000);
      wr(`REG_FAN_OPT, 16'h0001);
      cyc(3);
      check(fanOn_r, 16'h0001);
   endtask

   // e: expected cycles for 0 to 1000 counts; slack covers tick phase and pin sync
   task ramp(input [1:0] g, input [15:0] t, input [1:0] u, input [1:0] b, input integer e);
      integer n;
      reg [15:0] d;
      @(posedge clk) grpReq <= g;
      wr({3'h0, g}, t);
      wr({3'h1, g}, t);
      wr(`REG_UNIT, {14'h0000, u});
      wr(`REG_BASE_SEL, {14'h0000, b});
      @(posedge clk) runReq <= 1'b1;
      wait_freq(16'h03E8, 3 * e, n);
      check(n > e * 9 / 10 - 25 && n < e * 11 / 10 + 25, 16'h0001);
      rd(`REG_STATUS, d);
      check(d[3:2], g);
      @(posedge clk) runReq <= 1'b0;
      wait_freq(16'h0000, 3 * e, n);
      check(n > e * 9 / 10 - 25 && n < e * 11 / 10 + 25, 16'h0001);
   endtask

   task t_restore;
      @(posedge clk) energyReq <= 1'b1;
      @(posedge clk) energyReq <= 1'b0;
      @(posedge clk) energyReq <= 1'b1;
      @(posedge clk) energyReq <= 1'b0;
      @(posedge clk) faultReq <= 1'b1;
      @(posedge clk) faultReq <= 1'b0;
      wr(`REG_LOCK, 16'h0001);
      wr(`REG_KEYPAD_SP, 16'h0190);
      rc(`REG_KEYPAD_SP, 16'h1388);
      wr(`REG_LOCK, 16'h0000);
      wr(`REG_KEYPAD_SP, 16'h0190);
      rc(`REG_KEYPAD_SP, 16'h0190);
      wr(`REG_DECIMALS, 16'h0001);
      rc(`REG_KEYPAD_SP, 16'h0028);
      wr(`REG_MOTOR_FREQ, 16'h1234);
      wr(`REG_UNIT, 16'h0002);
      wr(`REG_RESTORE, 16'h0001);
      rc(`REG_RESTORE, 16'h0000);
      rc(`REG_UNIT, 16'h0001);
      rc(`REG_KEYPAD_SP, 16'h01F4);
      rc(`REG_MOTOR_FREQ, 16'h1234);
      rc(`REG_ENERGY, 16'h0002);
      rc(`REG_FAULT, 16'hABCD);
      rc(`REG_DECIMALS, 16'h0001);
      wr(`REG_RESTORE, 16'h0002);
      rc(`REG_RESTORE, 16'h0000);
      rc(`REG_ENERGY, 16'h0000);
      rc(`REG_FAULT, 16'h0000);
      rc(`REG_RUN_TIME, 16'h0000);
      rc(`REG_PWR_TIME, 16'h0000);
   endtask

   task stop_once;
      @(posedge clk) runReq <= 1'b1;
      cyc(5);
      @(posedge clk) runReq <= 1'b0;
      cyc(5);
   endtask

   task t_retain;
      wr(`REG_DIGITAL_SP, 16'h0123);
      stop_once;
      rc(`REG_DIGITAL_SP, 16'h0123);
      wr(`REG_RETAIN, 16'h0000);
      @(posedge clk) srcReq <= 1'b0;
      stop_once;
      rc(`REG_DIGITAL_SP, 16'h0123);
      @(posedge clk) srcReq <= 1'b1;
      stop_once;
      rc(`REG_DIGITAL_SP, 16'h01F4);
   endtask

   initial
   begin
      #3000000;
      mismatches = mismatches + 1;
      final_report;
   end

   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_defaults;
      t_fan;
      wr(`REG_DIGITAL_SP, 16'h03E8);
      ramp(2'h0, 16'h0001, 2'h0, 2'h2, 1250);
      ramp(2'h3, 16'h0002, 2'h0, 2'h2, 2500);
      ramp(2'h1, 16'h000A, 2'h1, 2'h2, 1250);
      ramp(2'h2, 16'h0001, 2'h0, 2'h0, 2500);
      ramp(2'h2, 16'h0064, 2'h2, 2'h1, 12500);
      t_restore;
      t_retain;
      final_report;
   end
endmodule
